// >>> verilog/cqs_core_params.svh
// Constants of the four-phase core: register offsets, flag positions, resets and timing
`ifndef CQS_CORE_PARAMS_SVH
`define CQS_CORE_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CQS_TOSC_NS     10
`define CQS_CLK_NS      10
`define CQS_PHASE_CYC   ((`CQS_TOSC_NS + `CQS_CLK_NS - 1) / `CQS_CLK_NS)
`define CQS_RAM_DEPTH   256

// ----------------------------------------------------------------------
// File register offsets
// ----------------------------------------------------------------------
`define CQS_ADDR_PCL     8'h02
`define CQS_ADDR_PC_HIGH_HOLDING_LATCH  8'h03
`define CQS_ADDR_ALUFLAG 8'h04
`define CQS_ADDR_EVT     8'h07
`define CQS_ADDR_WACC    8'h0a
`define CQS_ADDR_TBL_LO  8'h0e
`define CQS_ADDR_TBL_HI  8'h0f

// ----------------------------------------------------------------------
// Flag positions in the ALU flag register and reset values
// ----------------------------------------------------------------------
`define CQS_FLG_C        0
`define CQS_FLG_DC       1
`define CQS_FLG_Z        2
`define CQS_FLG_OV       3
`define CQS_RST_BYTE     8'h00

`endif

// >>> verilog/cqs_pkg.sv
// Types shared by the four-phase core and its helpers
package cqs_pkg;

   // Phase of the instruction cycle
   typedef enum logic [1:0] {
      cqs_phase_one   = 2'b00,
      cqs_phase_two   = 2'b01,
      cqs_phase_three = 2'b10,
      cqs_phase_four  = 2'b11
   } cqs_phase_e;

   // Operation codes; 4'hf is left unassigned
   typedef enum logic [3:0] {
      cqs_op_nop   = 4'h0,
      cqs_op_movwf = 4'h1,
      cqs_op_movf  = 4'h2,
      cqs_op_add   = 4'h3,
      cqs_op_sub   = 4'h4,
      cqs_op_and   = 4'h5,
      cqs_op_ior   = 4'h6,
      cqs_op_incf  = 4'h7,
      cqs_op_decf  = 4'h8,
      cqs_op_clrf  = 4'h9,
      cqs_op_bsf   = 4'ha,
      cqs_op_bcf   = 4'hb,
      cqs_op_btfsc = 4'hc,
      cqs_op_tlrd  = 4'hd,
      cqs_op_tlwt  = 4'he
   } cqs_op_e;

   typedef logic [7:0] cqs_byte_t;

   // Decoded instruction held through the cycle
   typedef struct packed {
      cqs_op_e   op;
      cqs_byte_t file;
      logic      dest;
      logic [2:0] bitsel;
      logic      tsel;
   } cqs_instr_s;

endpackage

// >>> verilog/cqs_link_if.sv
// Phase timing and ALU operand/result bundle between the core's modules
`timescale 1ns/100ps
interface cqs_link_if;
   import cqs_pkg::*;

   cqs_phase_e phase;
   logic       ph_last;
   cqs_op_e    alu_op;
   cqs_byte_t  alu_a;
   cqs_byte_t  alu_b;
   logic [2:0] alu_bit;
   cqs_byte_t  alu_res;
   logic [3:0] alu_flags;
   logic [3:0] alu_fmask;
   logic       alu_skip;

   modport seq  (output phase, output ph_last);
   modport alu  (input alu_op, input alu_a, input alu_b, input alu_bit,
                 output alu_res, output alu_flags, output alu_fmask, output alu_skip);
   modport core (input phase, input ph_last, input alu_res, input alu_flags,
                 input alu_fmask, input alu_skip,
                 output alu_op, output alu_a, output alu_b, output alu_bit);
endinterface

// >>> verilog/cqs_phase_seq.sv
// Four-phase sequencer of the instruction cycle
`timescale 1ns/100ps
`include "cqs_core_params.svh"
module cqs_phase_seq #(
   parameter int PHASE_CYC = `CQS_PHASE_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Phase output
   cqs_link_if.seq  link
);
   import cqs_pkg::*;

   localparam logic [7:0] LAST_CNT = 8'(PHASE_CYC - 1);

   logic [7:0] cnt_ff;
   cqs_phase_e phase_ff;

   // Clocks within one phase; one oscillator period each
   always_ff @(posedge clk_sys) begin
      if (rst || cnt_ff == LAST_CNT) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // Phase wraps four to one; reset restarts at phase one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_ff <= cqs_phase_one;
      end else if (cnt_ff == LAST_CNT) begin
         phase_ff <= cqs_phase_e'(phase_ff + 2'b01);
      end
   end

   assign link.phase   = phase_ff;
   assign link.ph_last = (cnt_ff == LAST_CNT);
endmodule

// >>> verilog/cqs_alu.sv
// Combinational ALU of the core with flag results and flag write mask
`timescale 1ns/100ps
`include "cqs_core_params.svh"
module cqs_alu (
   // Operands and results
   cqs_link_if.alu link
);
   import cqs_pkg::*;

   // Adder returning {overflow, digit carry, carry, sum}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      logic       ov;
      s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ov = (a[7] == b[7]) && (s[7] != a[7]);
      return {ov, h[4], s[8], s[7:0]};
   endfunction

   logic [10:0] sum;
   logic        arith;
   logic        zonly;
   cqs_byte_t   bmask;

   // Result per operation; arithmetic updates all four flags
   always_comb begin
      sum            = 11'h000;
      arith          = 1'b0;
      zonly          = 1'b0;
      bmask          = 8'h01 << link.alu_bit;
      link.alu_res   = link.alu_a;
      link.alu_skip  = 1'b0;
      unique case (link.alu_op)
         cqs_op_nop, cqs_op_tlwt: link.alu_res = link.alu_a;
         cqs_op_movwf: link.alu_res = link.alu_b;
         cqs_op_movf: zonly = 1'b1;
         cqs_op_add: begin
            sum   = add8(link.alu_a, link.alu_b, 1'b0);
            arith = 1'b1;
         end
         cqs_op_sub: begin
            sum   = add8(link.alu_a, ~link.alu_b, 1'b1); // carry set means no borrow
            arith = 1'b1;
         end
         cqs_op_incf: begin
            sum   = add8(link.alu_a, 8'h01, 1'b0);
            arith = 1'b1;
         end
         cqs_op_decf: begin
            sum   = add8(link.alu_a, 8'hff, 1'b0);
            arith = 1'b1;
         end
         cqs_op_and: begin
            link.alu_res = link.alu_a & link.alu_b;
            zonly        = 1'b1;
         end
         cqs_op_ior: begin
            link.alu_res = link.alu_a | link.alu_b;
            zonly        = 1'b1;
         end
         cqs_op_clrf: begin
            link.alu_res = 8'h00;
            zonly        = 1'b1;
         end
         // Whole byte comes in, one bit changes, whole byte goes out
         cqs_op_bsf: link.alu_res = link.alu_a | bmask;
         cqs_op_bcf: link.alu_res = link.alu_a & ~bmask;
         cqs_op_btfsc: link.alu_skip = ~|(link.alu_a & bmask);
         cqs_op_tlrd: link.alu_res = link.alu_b;
         // Unassigned code copies the operand unchanged to its destination with no flags; programs must not use it
         default: link.alu_res = link.alu_a;
      endcase
      if (arith) begin
         link.alu_res = sum[7:0];
      end
   end

   // Flag values and which of them the operation owns
   always_comb begin
      link.alu_flags                = 4'h0;
      link.alu_flags[`CQS_FLG_C]    = sum[8];
      link.alu_flags[`CQS_FLG_DC]   = sum[9];
      link.alu_flags[`CQS_FLG_OV]   = sum[10];
      link.alu_flags[`CQS_FLG_Z]    = (link.alu_res == 8'h00);
      link.alu_fmask                = arith ? 4'hf : 4'h0;
      link.alu_fmask[`CQS_FLG_Z]    = arith | zonly;
   end
endmodule

// >>> verilog/cqs_core.sv
// Four-phase core: instruction sequencing and special file register behaviour
// Summary of operation
// - The table data latch is 16 bits made of a low byte and a high byte, each reachable alone.
// - Each result goes to the working accumulator or to the addressed file register per dest; movwf, clrf, bsf, bcf and tlrd always write the file.
// - Every file register, special ones included, is read and written by the operand path.
// - A write to the ALU flag register is overridden by the flags that the operation owns.
// - A plain read of the low pc byte by an instruction copies the high pc byte into the holding latch.
// - A write of the low pc byte loads the high pc byte from the holding latch.
// - A read-modify-write of the low pc byte uses it as operand and reloads both pc bytes.
// - Bit set and clear read the whole register, change one bit and write it all back; bit test only reads it.
// - Hardware status bits are set only in phase one, so read-modify-write cannot lose them.
// - Each instruction cycle is four phases in order, one to four.
// - Each phase lasts one oscillator period.
// - Phase one decodes, two reads, three processes and four writes the result.
// - Skips, pc writes and table transfers take a second cycle executed as a no-operation.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "cqs_core_params.svh"
module cqs_core #(
   parameter int RAM_DEPTH = `CQS_RAM_DEPTH
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // Instruction feed
   input  wire logic               instr_valid,
   input  wire cqs_pkg::cqs_op_e   instr_op,
   input  wire logic [7:0]         instr_file,
   input  wire logic               instr_dest,
   input  wire logic [2:0]         instr_bit,
   input  wire logic               instr_tsel,
   output logic                    instr_take,
   // Hardware status events
   input  wire logic [7:0]         hw_event,
   // Register port
   input  wire logic [7:0]         bus_addr,
   input  wire logic [7:0]         bus_wdata,
   input  wire logic               bus_wr,
   input  wire logic               bus_rd,
   output logic [7:0]              bus_rdata,
   // Core state
   output logic [15:0]             pc_value,
   output logic [7:0]              wacc_value,
   output logic [7:0]              alu_flags_value,
   output cqs_pkg::cqs_phase_e     phase_value
);
   import cqs_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   cqs_link_if link ();

   cqs_instr_s ir_ff;
   logic       nop_cycle_ff;
   logic       take_ff;
   cqs_byte_t  operand_ff;
   cqs_byte_t  result_ff;
   logic [3:0] fl_res_ff;
   logic [3:0] fl_mask_ff;
   logic       skip_ff;
   cqs_byte_t  wacc_ff;
   cqs_byte_t  aluflag_ff;
   cqs_byte_t  pc_lo_ff;
   cqs_byte_t  pc_hi_ff;
   cqs_byte_t  pc_high_holding_latch_ff;
   cqs_byte_t  tbl_lo_ff;
   cqs_byte_t  tbl_hi_ff;
   cqs_byte_t  evt_ff;
   cqs_byte_t  pend_ff;
   cqs_byte_t  rdata_ff;
   cqs_byte_t  ram [RAM_DEPTH];

   cqs_phase_seq u_seq (.clk_sys(clk_sys), .rst(rst), .link(link));
   cqs_alu       u_alu (.link(link));

   // ----------------------------------------------------------------------
   // Decode of the held instruction
   // ----------------------------------------------------------------------
   logic      q1, q2, q3, q4;
   logic      reads_file, writes, to_file, f_we, w_we, pcl_read, two_cycle;
   logic      wp_en;
   cqs_byte_t wp_addr, wp_data, fl_base, fl_mask8;

   assign q1 = link.ph_last && (link.phase == cqs_phase_one);
   assign q2 = link.ph_last && (link.phase == cqs_phase_two);
   assign q3 = link.ph_last && (link.phase == cqs_phase_three);
   assign q4 = link.ph_last && (link.phase == cqs_phase_four);

   assign reads_file = !(ir_ff.op inside {cqs_op_nop, cqs_op_movwf, cqs_op_clrf, cqs_op_tlrd});
   assign writes     = !(ir_ff.op inside {cqs_op_nop, cqs_op_btfsc, cqs_op_tlwt});
   assign to_file    = ir_ff.dest ||
                       (ir_ff.op inside {cqs_op_movwf, cqs_op_clrf, cqs_op_bsf,
                                         cqs_op_bcf, cqs_op_tlrd});
   assign f_we       = q4 && writes && to_file;
   assign w_we       = q4 && writes && !to_file;
   // A read whose result does not go back to the low pc byte is a plain read
   assign pcl_read   = q2 && reads_file && (ir_ff.file == `CQS_ADDR_PCL) && !(writes && to_file);
   assign two_cycle  = skip_ff || (f_we && ir_ff.file == `CQS_ADDR_PCL) ||
                       (ir_ff.op inside {cqs_op_tlrd, cqs_op_tlwt});

   // One write port into the file; the core's phase-four write beats a bus write
   assign wp_en   = f_we || bus_wr;
   assign wp_addr = f_we ? ir_ff.file : bus_addr;
   assign wp_data = f_we ? result_ff : bus_wdata;

   // Reads of every file location, special ones included
   function automatic cqs_byte_t rd_file(input cqs_byte_t a);
      case (a)
         `CQS_ADDR_PCL:     return pc_lo_ff;
         `CQS_ADDR_PC_HIGH_HOLDING_LATCH:  return pc_high_holding_latch_ff;
         `CQS_ADDR_ALUFLAG: return aluflag_ff;
         `CQS_ADDR_EVT:     return evt_ff;
         `CQS_ADDR_WACC:    return wacc_ff;
         `CQS_ADDR_TBL_LO:  return tbl_lo_ff;
         `CQS_ADDR_TBL_HI:  return tbl_hi_ff;
         default:           return ram[a];
      endcase
   endfunction

   // ALU operands; a table read takes the selected latch byte as source
   assign link.alu_op  = ir_ff.op;
   assign link.alu_a   = operand_ff;
   assign link.alu_b   = (ir_ff.op == cqs_op_tlrd) ? (ir_ff.tsel ? tbl_hi_ff : tbl_lo_ff)
                                                   : wacc_ff;
   assign link.alu_bit = ir_ff.bitsel;

   // ----------------------------------------------------------------------
   // Phase actions
   // ----------------------------------------------------------------------
   // Phase one: decode, or a forced no-operation in the second cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ir_ff   <= '{op: cqs_op_nop, file: 8'h00, dest: 1'b0, bitsel: 3'h0, tsel: 1'b0};
         take_ff <= 1'b0;
      end else if (q1) begin
         take_ff <= instr_valid && !nop_cycle_ff;
         if (instr_valid && !nop_cycle_ff) begin
            ir_ff <= '{op: instr_op, file: instr_file, dest: instr_dest,
                       bitsel: instr_bit, tsel: instr_tsel};
         end else begin
            ir_ff <= '{op: cqs_op_nop, file: 8'h00, dest: 1'b0, bitsel: 3'h0, tsel: 1'b0};
         end
      end else begin
         take_ff <= 1'b0;
      end
   end

   // The extra cycle is flagged at phase four and consumed at the next phase one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nop_cycle_ff <= 1'b0;
      end else if (q4) begin
         nop_cycle_ff <= two_cycle;
      end else if (q1) begin
         nop_cycle_ff <= 1'b0;
      end
   end

   // Phase two reads the operand; phase three latches the ALU outcome
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         operand_ff <= `CQS_RST_BYTE;
         result_ff  <= `CQS_RST_BYTE;
         fl_res_ff  <= 4'h0;
         fl_mask_ff <= 4'h0;
         skip_ff    <= 1'b0;
      end else if (q2) begin
         operand_ff <= rd_file(ir_ff.file);
         skip_ff    <= 1'b0;
      end else if (q3) begin
         result_ff  <= link.alu_res;
         fl_res_ff  <= link.alu_flags;
         fl_mask_ff <= link.alu_fmask;
         skip_ff    <= link.alu_skip;
      end
   end

   // ----------------------------------------------------------------------
   // Special function registers
   // ----------------------------------------------------------------------
   // Working accumulator
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wacc_ff <= `CQS_RST_BYTE;
      end else if (w_we) begin
         wacc_ff <= result_ff;
      end else if (wp_en && wp_addr == `CQS_ADDR_WACC) begin
         wacc_ff <= wp_data;
      end
   end

   // Flags owned by the operation override whatever was written this cycle
   assign fl_base  = (wp_en && wp_addr == `CQS_ADDR_ALUFLAG) ? wp_data : aluflag_ff;
   assign fl_mask8 = q4 ? {4'h0, fl_mask_ff} : 8'h00;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aluflag_ff <= `CQS_RST_BYTE;
      end else begin
         aluflag_ff <= (fl_base & ~fl_mask8) | ({4'h0, fl_res_ff} & fl_mask8);
      end
   end

   // Program counter; the high byte is only reachable through the latch
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_lo_ff <= `CQS_RST_BYTE;
         pc_hi_ff <= `CQS_RST_BYTE;
      end else if (wp_en && wp_addr == `CQS_ADDR_PCL) begin
         pc_hi_ff <= pc_high_holding_latch_ff;
         pc_lo_ff <= wp_data;
      end else if (q4) begin
         {pc_hi_ff, pc_lo_ff} <= {pc_hi_ff, pc_lo_ff} + 16'h0001;
      end
   end

   // High holding latch
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_high_holding_latch_ff <= `CQS_RST_BYTE;
      end else if (wp_en && wp_addr == `CQS_ADDR_PC_HIGH_HOLDING_LATCH) begin
         pc_high_holding_latch_ff <= wp_data;
      end else if (pcl_read) begin
         pc_high_holding_latch_ff <= pc_hi_ff;
      end
   end

   // Table latch, two bytes written independently
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tbl_lo_ff <= `CQS_RST_BYTE;
         tbl_hi_ff <= `CQS_RST_BYTE;
      end else if (q4 && ir_ff.op == cqs_op_tlwt) begin
         if (ir_ff.tsel) begin
            tbl_hi_ff <= operand_ff;
         end else begin
            tbl_lo_ff <= operand_ff;
         end
      end else if (wp_en && wp_addr == `CQS_ADDR_TBL_LO) begin
         tbl_lo_ff <= wp_data;
      end else if (wp_en && wp_addr == `CQS_ADDR_TBL_HI) begin
         tbl_hi_ff <= wp_data;
      end
   end

   // Events wait in a pending set and land only in phase one, set over write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_ff <= `CQS_RST_BYTE;
         evt_ff  <= `CQS_RST_BYTE;
      end else begin
         pend_ff <= q1 ? 8'h00 : (pend_ff | hw_event);
         if (wp_en && wp_addr == `CQS_ADDR_EVT) begin
            evt_ff <= q1 ? (wp_data | pend_ff | hw_event) : wp_data;
         end else if (q1) begin
            evt_ff <= evt_ff | pend_ff | hw_event;
         end
      end
   end

   // General file; special offsets shadow the array
   always_ff @(posedge clk_sys) begin
      if (wp_en && !(wp_addr inside {`CQS_ADDR_PCL, `CQS_ADDR_PC_HIGH_HOLDING_LATCH, `CQS_ADDR_ALUFLAG,
                                     `CQS_ADDR_EVT, `CQS_ADDR_WACC, `CQS_ADDR_TBL_LO,
                                     `CQS_ADDR_TBL_HI})) begin
         ram[wp_addr] <= wp_data;
      end
   end

   // Bus read data stand in the cycle after the strobe only; no side effects
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_ff <= `CQS_RST_BYTE;
      end else begin
         rdata_ff <= bus_rd ? rd_file(bus_addr) : 8'h00;
      end
   end

   assign instr_take      = take_ff;
   assign bus_rdata       = rdata_ff;
   assign pc_value        = {pc_hi_ff, pc_lo_ff};
   assign wacc_value      = wacc_ff;
   assign alu_flags_value = aluflag_ff;
   assign phase_value     = link.phase;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_phase_cycle: assert property (
      (link.phase == cqs_phase_one) |=> (link.phase == cqs_phase_two) ##1
      (link.phase == cqs_phase_three) ##1 (link.phase == cqs_phase_four) ##1
      (link.phase == cqs_phase_one))
      else $error("phase order broken");
   chk_reset_restart: assert property ($past(rst) |-> link.phase == cqs_phase_one)
      else $error("no phase one after reset");
   chk_take_phase: assert property (
      take_ff |-> ($past(link.phase) == cqs_phase_one) && !$past(nop_cycle_ff))
      else $error("instruction taken outside decode");
   chk_clrf_flags: assert property (
      (q4 && ir_ff.op == cqs_op_clrf && ir_ff.file == `CQS_ADDR_ALUFLAG)
      |=> aluflag_ff == (8'h01 << `CQS_FLG_Z))
      else $error("cleared flag register lacks zero flag");
   chk_pcl_read: assert property (pcl_read |=> pc_high_holding_latch_ff == $past(pc_hi_ff))
      else $error("pc high not copied on read");
   chk_pcl_write: assert property (
      (f_we && ir_ff.file == `CQS_ADDR_PCL)
      |=> pc_hi_ff == $past(pc_high_holding_latch_ff) && pc_lo_ff == $past(result_ff))
      else $error("pc low write wrong");
   chk_pcl_rmw: assert property (
      (q3 && ir_ff.op == cqs_op_incf && ir_ff.dest && ir_ff.file == `CQS_ADDR_PCL)
      |=> ##1 pc_lo_ff == 8'($past(operand_ff, 2) + 8'h01))
      else $error("pc low rmw wrong");
   chk_bit_rmw: assert property (
      (q4 && ir_ff.op == cqs_op_bsf) |-> result_ff == (operand_ff | (8'h01 << ir_ff.bitsel)))
      else $error("bit set changed other bits");
   chk_evt_phase: assert property (
      ((evt_ff & ~$past(evt_ff)) != 8'h00)
      |-> $past(q1) || ($past(wp_en) && $past(wp_addr) == `CQS_ADDR_EVT))
      else $error("status bit set outside phase one");
   chk_dest_wacc: assert property (w_we |=> wacc_ff == $past(result_ff))
      else $error("result not in accumulator");
   chk_extra_nop: assert property (
      (q4 && two_cycle) |=> ##1 ir_ff.op == cqs_op_nop && !take_ff)
      else $error("second cycle not a no-operation");
   chk_tbl_bytes: assert property (
      (q4 && ir_ff.op == cqs_op_tlwt && ir_ff.tsel) |=> tbl_lo_ff == $past(tbl_lo_ff))
      else $error("table low byte disturbed");

   cov_skip_taken: cover property (q4 && skip_ff);
   cov_pcl_write: cover property (f_we && ir_ff.file == `CQS_ADDR_PCL);
   cov_evt_during_rmw: cover property (q4 && ir_ff.file == `CQS_ADDR_EVT && (hw_event != 8'h00));
   cov_table_read: cover property (q4 && ir_ff.op == cqs_op_tlrd);
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the four-phase core
`timescale 1ns/100ps
module tb_top;
   import cqs_pkg::*;
   // ------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------
   logic            clk_sys     = 1'b0;
   logic            rst         = 1'b1;
   logic            instr_valid = 1'b0;
   cqs_op_e         instr_op    = cqs_op_nop;
   logic [7:0]      instr_file  = 8'h00;
   logic            instr_dest  = 1'b0;
   logic [2:0]      instr_bit   = 3'h0;
   logic            instr_tsel  = 1'b0;
   logic [7:0]      hw_event    = 8'h00;
   logic [7:0]      bus_addr    = 8'h00;
   logic [7:0]      bus_wdata   = 8'h00;
   logic            bus_wr      = 1'b0;
   logic            bus_rd      = 1'b0;
   logic            instr_take;
   logic [7:0]      bus_rdata;
   logic [15:0]     pc_value;
   logic [7:0]      wacc_value;
   logic [7:0]      alu_flags_value;
   cqs_phase_e      phase_value;
   logic [7:0]      v;
   int              n_mismatch  = 0;
   int              num_checks  = 0;

   cqs_core cqs_core_inst (.clk_sys, .rst, .instr_valid, .instr_op, .instr_file, .instr_dest,
      .instr_bit, .instr_tsel, .instr_take, .hw_event, .bus_addr, .bus_wdata, .bus_wr,
      .bus_rd, .bus_rdata, .pc_value, .wacc_value, .alu_flags_value, .phase_value);

   // 100 MHz clock
   initial forever #5 clk_sys = ~clk_sys;

   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   // One-cycle write strobe; slave never stalls
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   // Offer one instruction, hold it until taken, return after its write phase
   task automatic exec(input cqs_op_e op, input logic [7:0] f, input logic d,
                       input logic [2:0] b);
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_op <= op; // assigned codes only
      instr_file <= f;
      instr_dest <= d;
      instr_bit <= b;
      repeat (20) begin
         @(posedge clk_sys);
         #1 if (instr_take === 1'b1) break;
      end
      chk("instr_take", instr_take, 1'b1);
      chk("take phase", phase_value, cqs_phase_two);
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_phase;
      for (int i = 0; i < 8; i++) begin
         #1 chk("phase", phase_value, i % 4);
         @(posedge clk_sys);
      end
   endtask
   task automatic t_table;
      wr(8'h0e, 8'ha5);
      wr(8'h0f, 8'h3c);
      rd(8'h0e, v);
      chk("table low", v, 8'ha5);
      rd(8'h0f, v);
      chk("table high", v, 8'h3c);
   endtask
   task automatic t_dest;
      wr(8'h20, 8'h05);
      wr(8'h0a, 8'h03);
      exec(cqs_op_add, 8'h20, 1'b0, 3'h0);
      chk("acc dest", wacc_value, 8'h08);
      rd(8'h20, v);
      chk("file kept", v, 8'h05);
      exec(cqs_op_add, 8'h20, 1'b1, 3'h0);
      rd(8'h20, v);
      chk("file dest", v, 8'h0d);
   endtask
   task automatic t_flags;
      wr(8'h04, 8'hf3);
      exec(cqs_op_clrf, 8'h04, 1'b1, 3'h0);
      rd(8'h04, v);
      chk("flag clear", v, 8'h04);
   endtask
   // Status set by hardware must survive a bit clear on the same register
   task automatic t_bits;
      wr(8'h20, 8'h81);
      exec(cqs_op_bsf, 8'h20, 1'b1, 3'h2);
      exec(cqs_op_bcf, 8'h20, 1'b1, 3'h7);
      rd(8'h20, v);
      chk("bit ops", v, 8'h05);
      wr(8'h07, 8'h80);
      // Event pulse lands after the operand read, so it must wait for the next phase one
      fork
         exec(cqs_op_bcf, 8'h07, 1'b1, 3'h7);
         begin
            @(posedge instr_take);
            @(posedge clk_sys);
            hw_event <= 8'h02;
            @(posedge clk_sys);
            hw_event <= 8'h00;
         end
      join
      rd(8'h07, v);
      chk("event kept", v, 8'h02);
   endtask
   task automatic t_pc;
      wr(8'h03, 8'h12);
      wr(8'h0a, 8'h34);
      exec(cqs_op_movwf, 8'h02, 1'b1, 3'h0);
      chk("pc write", pc_value, 16'h1234);
      wr(8'h03, 8'h77);
      exec(cqs_op_movf, 8'h02, 1'b0, 3'h0);
      chk("pc read", wacc_value, 8'h35);
      rd(8'h03, v);
      chk("latch copy", v, 8'h12);
      wr(8'h03, 8'h40);
      exec(cqs_op_incf, 8'h02, 1'b1, 3'h0);
      chk("pc rmw", pc_value, 16'h4039);
   endtask
   // Table latch moves and a taken skip, each followed by its forced no-operation
   task automatic t_tblop;
      wr(8'h21, 8'h6e);
      instr_tsel <= 1'b1;
      exec(cqs_op_tlwt, 8'h21, 1'b0, 3'h0);
      rd(8'h0f, v);
      chk("tlwt high", v, 8'h6e);
      rd(8'h0e, v);
      chk("tlwt low kept", v, 8'ha5);
      exec(cqs_op_tlrd, 8'h22, 1'b1, 3'h0);
      rd(8'h22, v);
      chk("tlrd high", v, 8'h6e);
      exec(cqs_op_btfsc, 8'h20, 1'b0, 3'h1);
      exec(cqs_op_incf, 8'h20, 1'b1, 3'h0);
      rd(8'h20, v);
      chk("after skip", v, 8'h06);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_phase;
      t_table;
      t_dest;
      t_flags;
      t_bits;
      t_pc;
      t_tblop;
      print_verdict;
   end
   // Watchdog at 2000 cycles, far beyond the roughly 160 cycles the tests need
   initial begin
      #20000;
      n_mismatch++;
      print_verdict;
   end
endmodule
